//--- inc/pixel_link_pkg.sv
// Shared constants, types and helpers for the user video pixel link
package pixel_link_pkg;

   localparam int unsigned PIX_W         = 48;   // Every pixel bus, any depth
   localparam int unsigned PIX_LANES     = 4;
   localparam int unsigned COMP_W        = 16;
   localparam int unsigned CNT_W         = 16;
   localparam int unsigned SLOT_HI_MSB   = 47;   // Red, Cr, chroma, luma-only
   localparam int unsigned SLOT_MID_MSB  = 31;   // Green, Y, 4:2:2 luma
   localparam int unsigned SLOT_LO_MSB   = 15;   // Blue, Cb

   // Link clock limit and the divider the source end uses to make it
   localparam int unsigned VID_CLK_MAX_MHZ = 150;
   localparam int unsigned SYS_CLK_MHZ     = 125;
   localparam int unsigned VID_HALF_CYC    =
      (SYS_CLK_MHZ + 2 * VID_CLK_MAX_MHZ - 1) / (2 * VID_CLK_MAX_MHZ);

   typedef enum logic [1:0] {
      FMT_RGB                   = 2'h0,
      FMT_CHROMA_FULL_FORMAT    = 2'h1,
      FMT_CHROMA_SUBSAMPLED     = 2'h2,
      FMT_LUMA_ONLY_FORMAT      = 2'h3
   } fmt_e;

   typedef enum logic [2:0] {
      BPC_6  = 3'h0,
      BPC_8  = 3'h1,
      BPC_10 = 3'h2,
      BPC_12 = 3'h3,
      BPC_16 = 3'h4
   } bpc_e;

   typedef enum logic [1:0] {
      LANES_1 = 2'h0,
      LANES_2 = 2'h1,
      LANES_4 = 2'h2
   } lanes_e;

   typedef enum logic [1:0] {
      PPC_1 = 2'h0,
      PPC_2 = 2'h1,
      PPC_4 = 2'h2
   } ppc_e;

   typedef struct packed {
      lanes_e lanes;
      ppc_e   ppc;
      fmt_e   fmt;
      bpc_e   bpc;
   } vid_cfg_s;

   typedef logic [PIX_LANES-1:0][PIX_W-1:0]  pix_t;
   typedef logic [PIX_LANES-1:0][COMP_W-1:0] comp_t;

   function automatic int unsigned bpc_width(input bpc_e b);
      case (b)
         BPC_6:   return 6;
         BPC_8:   return 8;
         BPC_10:  return 10;
         BPC_12:  return 12;
         default: return 16;
      endcase
   endfunction

   function automatic logic [COMP_W-1:0] comp_mask(input bpc_e b);
      return 16'hFFFF >> (COMP_W - bpc_width(b));
   endfunction

   // Right-justified component from an MSB-aligned slot; low bits dropped
   function automatic logic [COMP_W-1:0] comp_take(input logic [PIX_W-1:0] w,
                                                   input int unsigned msb,
                                                   input bpc_e b);
      logic [PIX_W-1:0] t;
      t = w >> (msb + 1 - bpc_width(b));
      return t[COMP_W-1:0] & comp_mask(b);
   endfunction

   // MSB-aligned placement, unused low bits driven to zero
   function automatic logic [PIX_W-1:0] comp_put(input logic [COMP_W-1:0] c,
                                                 input int unsigned msb,
                                                 input bpc_e b);
      logic [PIX_W-1:0] t;
      t = {32'h0, c & comp_mask(b)};
      return t << (msb + 1 - bpc_width(b));
   endfunction

   function automatic logic [2:0] ppc_count(input ppc_e p);
      case (p)
         PPC_1:   return 3'h1;
         PPC_2:   return 3'h2;
         default: return 3'h4;
      endcase
   endfunction

   // Second bus needs two lanes and two pixels; third/fourth need four of each
   function automatic logic lane_used(input int unsigned k, input lanes_e l,
                                      input ppc_e p);
      if (k == 0) begin
         return 1'b1;
      end
      if (k == 1) begin
         return (p != PPC_1) && (l != LANES_1);
      end
      return (p == PPC_4) && (l == LANES_4);
   endfunction

endpackage

//--- inc/pixel_link_if.sv
// Video timing and pixel link between a video source and the pixel input block
`timescale 1ns/10ps
interface pixel_link_if;
   import pixel_link_pkg::*;
   logic       vid_clk;
   logic       vid_rst;
   logic       vsync;
   logic       hsync;
   logic       field_odd;
   logic       data_valid;
   logic [PIX_W-1:0] pixel_bus_first;
   logic [PIX_W-1:0] pixel_bus_second;
   logic [PIX_W-1:0] pixel_bus_third;
   logic [PIX_W-1:0] pixel_bus_fourth;

   modport source (output vid_clk, output vid_rst, output vsync, output hsync,
                   output field_odd, output data_valid, output pixel_bus_first,
                   output pixel_bus_second, output pixel_bus_third,
                   output pixel_bus_fourth);
   modport sink   (input vid_clk, input vid_rst, input vsync, input hsync,
                   input field_odd, input data_valid, input pixel_bus_first,
                   input pixel_bus_second, input pixel_bus_third,
                   input pixel_bus_fourth);
endinterface

//--- design/video_timing_source.sv
// Video source end: divided link clock, sync timing and packed test pixels
`timescale 1ns/10ps
module video_timing_source
   import pixel_link_pkg::*;
(
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   pixel_link_if.source          link,
   input  wire logic             run_i,
   input  wire logic             interlace_i,
   input  wire fmt_e             fmt_i,
   input  wire bpc_e             bpc_i,
   input  wire ppc_e             ppc_i,
   input  wire logic [CNT_W-1:0] h_sync_i,
   input  wire logic [CNT_W-1:0] h_bp_i,
   input  wire logic [CNT_W-1:0] h_active_i,
   input  wire logic [CNT_W-1:0] h_fp_i,
   input  wire logic [CNT_W-1:0] v_sync_i,
   input  wire logic [CNT_W-1:0] v_bp_i,
   input  wire logic [CNT_W-1:0] v_active_i,
   input  wire logic [CNT_W-1:0] v_fp_i,
   output logic                  frame_start_o,
   output logic                  busy_o
);

   typedef enum logic [4:0] {
      V_IDLE   = 5'h01,
      V_SYNC   = 5'h02,
      V_BACK   = 5'h04,
      V_ACTIVE = 5'h08,
      V_FRONT  = 5'h10
   } vphase_e;

   typedef struct packed {
      logic [7:0]       div;
      logic             clk;
      logic             vrst;
      vphase_e          phase;
      logic [CNT_W-1:0] hcnt;
      logic [CNT_W-1:0] vcnt;
      logic [CNT_W-1:0] xcnt;
      logic [CNT_W-1:0] ycnt;
      logic [CNT_W-1:0] frame;
      logic             vs;
      logic             hs;
      logic             de;
      logic             odd;
      logic             fstart;
      pix_t             pix;
   } src_s;

   src_s s;
   src_s n;

   logic             fall;
   logic             line_end;
   logic [CNT_W-1:0] act_lo;
   logic [CNT_W-1:0] act_hi;
   logic [CNT_W-1:0] line_tot;
   logic [CNT_W-1:0] ph_len;
   logic [CNT_W-1:0] x;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; all link outputs change on the link clock's falling edge
   always_comb begin
      n          = s;
      n.fstart   = 1'b0;
      x          = '0;
      fall       = s.clk && (s.div == 8'(VID_HALF_CYC - 1));
      act_lo     = 16'(h_sync_i + h_bp_i);
      act_hi     = 16'(act_lo + h_active_i);
      line_tot   = 16'(act_hi + h_fp_i);
      line_end   = (s.hcnt == 16'(line_tot - 16'h1));
      unique case (s.phase)
         V_SYNC:   ph_len = v_sync_i;
         V_BACK:   ph_len = v_bp_i;
         V_ACTIVE: ph_len = v_active_i;
         default:  ph_len = v_fp_i;
      endcase
      // Clock divider keeps the link clock under its ceiling
      if (s.div == 8'(VID_HALF_CYC - 1)) begin
         n.div = '0;
         n.clk = ~s.clk;
      end else begin
         n.div = 8'(s.div + 8'h1);
      end
      if (fall) begin
         n.vrst = ~run_i;
         n.vs   = (s.phase == V_SYNC);
         n.hs   = (s.phase != V_IDLE) && (s.hcnt < h_sync_i);
         // One valid spans the whole active span of an active line
         n.de   = (s.phase == V_ACTIVE) && (s.hcnt >= act_lo) && (s.hcnt < act_hi);
         n.pix  = '0;
         if (n.de) begin
            for (int unsigned k = 0; k < PIX_LANES; k++) begin
               if (k < ppc_count(ppc_i)) begin
                  x = 16'(s.xcnt + 16'(k));
                  unique case (fmt_i)
                     FMT_CHROMA_SUBSAMPLED: begin
                        n.pix[k] = comp_put(s.frame, SLOT_HI_MSB, bpc_i) |
                                   comp_put(x, SLOT_MID_MSB, bpc_i);
                     end
                     FMT_LUMA_ONLY_FORMAT: begin
                        n.pix[k] = comp_put(x, SLOT_HI_MSB, bpc_i);
                     end
                     default: begin
                        n.pix[k] = comp_put(x, SLOT_HI_MSB, bpc_i) |
                                   comp_put(s.ycnt, SLOT_MID_MSB, bpc_i) |
                                   comp_put(s.frame, SLOT_LO_MSB, bpc_i);
                     end
                  endcase
               end
            end
            n.xcnt = 16'(s.xcnt + 16'(ppc_count(ppc_i)));
         end
         // Raster counters
         if (!run_i) begin
            n.phase = V_IDLE;
            n.hcnt  = '0;
            n.vcnt  = '0;
            n.xcnt  = '0;
         end else if (s.phase == V_IDLE) begin
            n.phase  = V_SYNC;
            n.fstart = 1'b1;
         end else if (!line_end) begin
            n.hcnt = 16'(s.hcnt + 16'h1);
         end else begin
            n.hcnt = '0;
            n.xcnt = '0;
            if (s.phase == V_ACTIVE) begin
               n.ycnt = 16'(s.ycnt + 16'h1);
            end
            if (s.vcnt + 16'h1 < ph_len) begin
               n.vcnt = 16'(s.vcnt + 16'h1);
            end else begin
               n.vcnt = '0;
               unique case (s.phase)
                  V_SYNC:   n.phase = V_BACK;
                  V_BACK:   n.phase = V_ACTIVE;
                  V_ACTIVE: n.phase = V_FRONT;
                  default: begin
                     n.phase  = V_SYNC;
                     n.fstart = 1'b1;
                     n.ycnt   = '0;
                     n.frame  = 16'(s.frame + 16'h1);
                     n.odd    = interlace_i ? ~s.odd : 1'b1;
                  end
               endcase
            end
         end
      end
   end

   // Single state register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s       <= '0;
         s.vrst  <= 1'b1;
         s.odd   <= 1'b1;
         s.phase <= V_IDLE;
      end else begin
         s <= n;
      end
   end

   // Link pins straight from state flops
   assign link.vid_clk          = s.clk;
   assign link.vid_rst          = s.vrst;
   assign link.vsync            = s.vs;
   assign link.hsync            = s.hs;
   assign link.field_odd        = s.odd;
   assign link.data_valid       = s.de;
   assign link.pixel_bus_first  = s.pix[0];
   assign link.pixel_bus_second = s.pix[1];
   assign link.pixel_bus_third  = s.pix[2];
   assign link.pixel_bus_fourth = s.pix[3];
   assign frame_start_o         = s.fstart;
   assign busy_o                = (s.phase != V_IDLE);

endmodule

//--- design/pixel_input_sink.sv
// Pixel input end: samples the link, unpacks pixels, measures frame timing
`timescale 1ns/10ps
// Behaviour
// - Pixel logic runs on video clock, 150 MHz max
// - Sync pulses active high, any width
// - Field input high odd, low even
// - One valid qualifies all pixel buses
// - Source holds valid through whole active line
// - Capture pixels only while valid high
// - Ignore second bus unless enabled, multi-lane
// - Ignore buses three/four unless enabled, four lanes
// - Vertical sync ends one frame, starts next
// - Back porch counts hsyncs before first active
// - Front porch counts hsyncs after last active
// - Vsync trailing edge resets image path state
// - Horizontal porches measured in video clocks; only the back porch is measured
// - Every pixel bus is 48 bits
// - Narrow components MSB-packed, low bits ignored
// - RGB/444 slots at 47, 31, 15 down
// - 4:2:2 chroma high, luma mid, Cr/Cb alternate
// - One, two or four pixels per clock
module pixel_input_sink
   import pixel_link_pkg::*;
(
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   pixel_link_if.sink            link,
   input  wire vid_cfg_s         cfg_i,
   output logic                  pix_valid_o,
   output logic [PIX_LANES-1:0]  lane_valid_o,
   output comp_t                 comp_hi_o,
   output comp_t                 comp_mid_o,
   output comp_t                 comp_lo_o,
   output logic [PIX_LANES-1:0]  chroma_is_cb_o,
   output logic                  frame_start_o,
   output logic                  frame_done_o,
   output logic [CNT_W-1:0]      meas_vbp_o,
   output logic [CNT_W-1:0]      meas_vfp_o,
   output logic [CNT_W-1:0]      meas_lines_o,
   output logic [CNT_W-1:0]      meas_ppl_o,
   output logic [CNT_W-1:0]      meas_hbp_o,
   output logic                  meas_field_odd_o
);

   typedef enum logic [2:0] {
      P_WAIT   = 3'h1,
      P_BACK   = 3'h2,
      P_ACTIVE = 3'h4
   } vphase_e;

   typedef struct packed {
      logic [CNT_W-1:0] vbp;
      logic [CNT_W-1:0] vfp;
      logic [CNT_W-1:0] lines;
      logic [CNT_W-1:0] ppl;
      logic [CNT_W-1:0] hbp;
      logic             odd;
   } stat_s;

   // Link-clock domain state
   typedef struct packed {
      vid_cfg_s         cfg_m;
      vid_cfg_s         cfg_s;
      vid_cfg_s         cfg_a;
      logic             vrst;
      logic             vs;
      logic             vs_p;
      logic             hs;
      logic             hs_p;
      logic             de;
      logic             de_p;
      logic             odd;
      pix_t             pix;
      vphase_e          phase;
      logic [CNT_W-1:0] vbp;
      logic [CNT_W-1:0] vfp;
      logic [CNT_W-1:0] lines;
      logic [CNT_W-1:0] hcnt;
      logic [CNT_W-1:0] hbp;
      logic [CNT_W-1:0] pcnt;
      logic [CNT_W-1:0] ppl;
      logic             par;
      logic             out_v;
      logic [PIX_LANES-1:0] lane_v;
      comp_t            ca;
      comp_t            cb;
      comp_t            cc;
      logic [PIX_LANES-1:0] cbf;
      logic             fstart;
      stat_s            stat;
      logic             tgl;
   } vid_s;

   // System-clock domain state
   typedef struct packed {
      logic  tg_m;
      logic  tg_s;
      logic  tg_p;
      logic  done;
      stat_s meas;
   } sys_s;

   vid_s v;
   vid_s vn;
   sys_s y;
   sys_s yn;

   logic vs_rise;
   logic vs_fall;
   logic hs_rise;
   logic hs_fall;
   logic de_rise;
   logic de_fall;

   ////////////////////////////////////////////////////////////////////////////
   // Link side, clocked by the video clock from the source
   always_comb begin
      vn        = v;
      vn.fstart = 1'b0;
      // Quasi-static config; only applied at a vsync trailing edge
      vn.cfg_m  = cfg_i;
      vn.cfg_s  = v.cfg_m;
      // Plain rising-edge sampling of the link pins
      vn.vrst   = link.vid_rst;
      vn.vs     = link.vsync;
      vn.hs     = link.hsync;
      vn.de     = link.data_valid;
      vn.odd    = link.field_odd;
      vn.pix    = {link.pixel_bus_fourth, link.pixel_bus_third,
                   link.pixel_bus_second, link.pixel_bus_first};
      vn.vs_p   = v.vs;
      vn.hs_p   = v.hs;
      vn.de_p   = v.de;
      // Edges only, so no pulse width is assumed
      vs_rise   = v.vs & ~v.vs_p;
      vs_fall   = ~v.vs & v.vs_p;
      hs_rise   = v.hs & ~v.hs_p;
      hs_fall   = ~v.hs & v.hs_p;
      de_rise   = v.de & ~v.de_p;
      de_fall   = ~v.de & v.de_p;

      // Horizontal timing in video clocks; first porch clock counts as one
      vn.hcnt = hs_fall ? 16'h0001 : 16'(v.hcnt + 16'h1);
      if (de_rise) begin
         vn.hbp = v.hcnt;
      end
      // Pixels per line: valid clocks times pixels per clock
      if (v.de) begin
         vn.pcnt = 16'((de_rise ? 16'h0 : v.pcnt) + 16'(ppc_count(v.cfg_a.ppc)));
      end
      if (de_fall) begin
         vn.ppl   = v.pcnt;
         vn.lines = 16'(v.lines + 16'h1);
      end

      // Vertical framing
      unique case (v.phase)
         P_BACK: begin
            if (v.de) begin
               vn.phase = P_ACTIVE;
            end else if (hs_rise) begin
               vn.vbp = 16'(v.vbp + 16'h1);
            end
         end
         P_ACTIVE: begin
            if (v.de) begin
               vn.vfp = '0;
            end else if (hs_rise) begin
               vn.vfp = 16'(v.vfp + 16'h1);
            end
         end
         default: ;
      endcase
      // Frame close at vsync start; only a frame we saw open counts
      if (vs_rise && v.phase != P_WAIT) begin
         vn.stat = '{vbp: v.vbp, vfp: v.vfp, lines: v.lines,
                     ppl: v.ppl, hbp: v.hbp, odd: v.odd};
         vn.tgl  = ~v.tgl;
      end

      // Pixel capture, one valid for all buses
      vn.out_v = v.de;
      if (v.de) begin
         for (int unsigned k = 0; k < PIX_LANES; k++) begin
            vn.lane_v[k] = lane_used(k, v.cfg_a.lanes, v.cfg_a.ppc);
            vn.ca[k]     = '0;
            vn.cb[k]     = '0;
            vn.cc[k]     = '0;
            vn.cbf[k]    = 1'b0;
            if (vn.lane_v[k]) begin
               unique case (v.cfg_a.fmt)
                  FMT_CHROMA_SUBSAMPLED: begin
                     vn.ca[k]  = comp_take(v.pix[k], SLOT_HI_MSB, v.cfg_a.bpc);
                     vn.cb[k]  = comp_take(v.pix[k], SLOT_MID_MSB, v.cfg_a.bpc);
                     vn.cbf[k] = (de_rise ? 1'b0 : v.par) ^ k[0];
                  end
                  FMT_LUMA_ONLY_FORMAT: begin
                     vn.cb[k]  = comp_take(v.pix[k], SLOT_HI_MSB, v.cfg_a.bpc);
                  end
                  default: begin
                     vn.ca[k]  = comp_take(v.pix[k], SLOT_HI_MSB, v.cfg_a.bpc);
                     vn.cb[k]  = comp_take(v.pix[k], SLOT_MID_MSB, v.cfg_a.bpc);
                     vn.cc[k]  = comp_take(v.pix[k], SLOT_LO_MSB, v.cfg_a.bpc);
                  end
               endcase
            end
         end
         // Cr/Cb phase carries over when pixels per clock is odd
         vn.par = (de_rise ? 1'b0 : v.par) ^ (v.cfg_a.ppc == PPC_1);
      end else begin
         vn.lane_v = '0;
      end

      // Trailing edge of vsync restarts the image path
      if (vs_fall) begin
         vn.cfg_a  = v.cfg_s;
         vn.phase  = P_BACK;
         vn.vbp    = '0;
         vn.vfp    = '0;
         vn.lines  = '0;
         vn.par    = 1'b0;
         vn.fstart = 1'b1;
      end
      // Video reset holds the path idle; handshake state survives it
      if (v.vrst) begin
         vn.phase  = P_WAIT;
         vn.vbp    = '0;
         vn.vfp    = '0;
         vn.lines  = '0;
         vn.par    = 1'b0;
         vn.out_v  = 1'b0;
         vn.lane_v = '0;
         vn.fstart = 1'b0;
      end
   end

   // Link-domain register, video clock up to its ceiling
   always_ff @(posedge link.vid_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         v       <= '0;
         v.vrst  <= 1'b1;
         v.phase <= P_WAIT;
      end else begin
         v <= vn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System side: toggle crossing for the per-frame measurements
   always_comb begin
      yn      = y;
      yn.tg_m = v.tgl;
      yn.tg_s = y.tg_m;
      yn.tg_p = y.tg_s;
      yn.done = y.tg_s ^ y.tg_p;
      // Stat word is held for a whole frame after its toggle
      if (y.tg_s ^ y.tg_p) begin
         yn.meas = v.stat;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         y <= '0;
      end else begin
         y <= yn;
      end
   end

   // Outputs, all from flops
   assign pix_valid_o      = v.out_v;
   assign lane_valid_o     = v.lane_v;
   assign comp_hi_o        = v.ca;
   assign comp_mid_o       = v.cb;
   assign comp_lo_o        = v.cc;
   assign chroma_is_cb_o   = v.cbf;
   assign frame_start_o    = v.fstart;
   assign frame_done_o     = y.done;
   assign meas_vbp_o       = y.meas.vbp;
   assign meas_vfp_o       = y.meas.vfp;
   assign meas_lines_o     = y.meas.lines;
   assign meas_ppl_o       = y.meas.ppl;
   assign meas_hbp_o       = y.meas.hbp;
   assign meas_field_odd_o = y.meas.odd;

endmodule

//--- bench/pixel_link_props.sv
// Checker of framing on the video link
`timescale 1ns/10ps
module pixel_link_props (
   input wire logic vid_clk,
   input wire logic vid_rst,
   input wire logic vsync,
   input wire logic hsync,
   input wire logic field_odd,
   input wire logic data_valid
);
   // One domain: link clock and video reset
   default clocking @(posedge vid_clk); endclocking
   default disable iff (vid_rst);
   ////////////////////////////////
   // Next line start; bound covers the longest line used
   sequence next_line;
      ##[1:64] $rose(hsync);
   endsequence
   sequence vsync_line;
      vsync [*4];
   endsequence
   AST_VSYNC_AT_LINE: assert property ($rose(vsync) |-> hsync)
      else $error("vsync off line start");
   AST_VSYNC_WIDTH: assert property ($rose(vsync) |-> vsync_line)
      else $error("vsync too short");
   AST_VALID_OFF_SYNC: assert property (data_valid |-> !(hsync || vsync))
      else $error("valid inside sync");
   AST_VALID_HOLD: assert property ($rose(data_valid) |=> data_valid)
      else $error("valid toggled");
   AST_VALID_ONE_RUN: assert property (
      $fell(data_valid) |-> !data_valid throughout next_line)
      else $error("valid back within line");
   AST_BACK_PORCH: assert property (
      $fell(vsync) |-> !data_valid throughout next_line)
      else $error("no back porch line");
   AST_FRONT_PORCH: assert property (
      $fell(data_valid) |-> !vsync throughout next_line)
      else $error("no front porch line");
   AST_FIELD_STEADY: assert property (data_valid |-> $stable(field_odd))
      else $error("field moved in line");
endmodule

//--- bench/source_video_pixel_input_test.sv
// Bench: video source end driving the pixel input end
`timescale 1ns/10ps
module source_video_pixel_input_test;
   import pixel_link_pkg::*;
   logic        sys_clk_i, rst_n_i, run_i, busy, pv, fd, fodd, used, ilace, sfs, kfs;
   logic [3:0]  lv, cb;
   comp_t       hi, mid, lo;
   vid_cfg_s    cfg;
   logic [15:0] h_bp, h_act, v_bp, v_fp, vbp, vfp, lines, ppl, xe, pn, e, hbp, ln;
   int          fails = 0, checked = 0, n, fs_src, fs_snk;
   // Table of runs: formats, depths, widths, lanes
   fmt_e   fmts[5] = '{FMT_RGB, FMT_CHROMA_FULL_FORMAT, FMT_CHROMA_SUBSAMPLED,
                       FMT_LUMA_ONLY_FORMAT, FMT_RGB};
   bpc_e   bpcs[5] = '{BPC_8, BPC_6, BPC_10, BPC_12, BPC_16};
   ppc_e   ppcs[5] = '{PPC_1, PPC_2, PPC_2, PPC_4, PPC_4};
   lanes_e lns[5]  = '{LANES_1, LANES_1, LANES_2, LANES_2, LANES_4};
   pixel_link_if lnk ();
   video_timing_source u_video_timing_source (.sys_clk_i, .rst_n_i, .link(lnk),
      .run_i, .interlace_i(ilace), .fmt_i(cfg.fmt), .bpc_i(cfg.bpc), .ppc_i(cfg.ppc),
      .h_sync_i(16'h0002), .h_bp_i(h_bp), .h_active_i(h_act), .h_fp_i(16'h0002),
      .v_sync_i(16'h0001), .v_bp_i(v_bp), .v_active_i(16'h0003), .v_fp_i(v_fp),
      .frame_start_o(sfs), .busy_o(busy));
   pixel_input_sink u_pixel_input_sink (.sys_clk_i, .rst_n_i, .link(lnk), .cfg_i(cfg),
      .pix_valid_o(pv), .lane_valid_o(lv), .comp_hi_o(hi), .comp_mid_o(mid),
      .comp_lo_o(lo), .chroma_is_cb_o(cb), .frame_start_o(kfs), .frame_done_o(fd),
      .meas_vbp_o(vbp), .meas_vfp_o(vfp), .meas_lines_o(lines), .meas_ppl_o(ppl),
      .meas_hbp_o(hbp), .meas_field_odd_o(fodd));
   pixel_link_props u_pixel_link_props (.vid_clk(lnk.vid_clk), .vid_rst(lnk.vid_rst),
      .vsync(lnk.vsync), .hsync(lnk.hsync), .field_odd(lnk.field_odd),
      .data_valid(lnk.data_valid));
   ////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Bounded wait for a measured frame; a hang ends the run
   task automatic wait_done;
      for (n = 0; n < 3000 && fd !== 1'b1; n++) @(negedge sys_clk_i);
      if (n == 3000) begin
         fails++;
         end_of_test();
      end
      @(negedge sys_clk_i);
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // Watchdog: all runs need far fewer cycles
   initial begin
      #400000;
      fails++;
      end_of_test();
   end
   // Source frame starts, sampled mid-cycle to stay clear of the launch edge
   always @(negedge sys_clk_i) begin
      if (sfs === 1'b1) begin
         fs_src++;
      end
   end
   // Pixel index restarts per line, line index per frame start
   always @(negedge lnk.vid_clk) begin
      if (kfs === 1'b1) begin
         fs_snk++;
         ln = 16'h0000;
      end
      if (pv !== 1'b1) begin
         if (xe != 16'h0000) begin
            ln = ln + 16'h0001;
         end
         xe = 16'h0000;
      end else begin
         for (int k = 0; k < 4; k++) begin
            used = k == 0 || (k == 1 && cfg.ppc != PPC_1 && cfg.lanes != LANES_1)
                   || (cfg.ppc == PPC_4 && cfg.lanes == LANES_4);
            e = xe + 16'(k);
            chk(lv[k], used);
            if (used && cfg.fmt inside {FMT_RGB, FMT_CHROMA_FULL_FORMAT}) begin
               chk(hi[k], e);
               chk(mid[k], ln);
            end else if (used) begin
               chk(mid[k], e);
            end else begin
               chk(hi[k] | mid[k] | lo[k], 16'h0000);
            end
            if (used && cfg.fmt == FMT_CHROMA_SUBSAMPLED) begin
               chk(cb[k], e[0]);
            end
         end
         xe = xe + pn;
      end
   end
   // Main sequence: config changed only while stopped, one run each
   initial begin
      rst_n_i = 1'b0;
      run_i = 1'b0;
      ilace = 1'b0;
      cfg = '0;
      {h_bp, h_act, v_bp, v_fp, pn} = {16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0001};
      repeat (4) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      for (int i = 0; i < 5; i++) begin
         cfg = {lns[i], ppcs[i], fmts[i], bpcs[i]};
         pn = (cfg.ppc == PPC_1) ? 16'h0001 : (cfg.ppc == PPC_2) ? 16'h0002 : 16'h0004;
         h_bp = 16'(1 + i);
         h_act = 16'(2 + i);
         v_bp = 16'(1 + i);
         v_fp = 16'(1 + i % 2);
         ilace = (i == 1);
         fs_src = 0;
         fs_snk = 0;
         @(negedge sys_clk_i);
         run_i = 1'b1;
         wait_done();
         chk(fodd, !ilace);
         wait_done();
         chk(vbp, v_bp);
         chk(vfp, v_fp);
         chk(lines, 16'h0003);
         chk(fodd, 1'b1);
         chk(ppl, h_act * pn);
         chk(hbp, h_bp);
         run_i = 1'b0;
         for (n = 0; n < 300 && (busy !== 1'b0 || lnk.vid_rst !== 1'b1); n++)
            @(negedge sys_clk_i);
         if (n == 300) begin
            fails++;
            end_of_test();
         end
         @(negedge sys_clk_i);
         chk(16'(fs_src), 16'h0003);
         chk(16'(fs_snk), 16'h0002);
         $display("test %0d ended", i);
      end
      end_of_test();
   end
endmodule
